// ==== rotdec_knob_model.sv ====
// partner model: one quadrature encoder turned by tasks
// assumes a free-running bench clock; phases rest at 00 from time zero
`timescale 1ns/10ps
module rotdec_knob_model (
   // clock
   input  wire logic clk,
   // phases
   output logic      a,
   output logic      b
);
   logic [1:0] pos_q = 2'h0;
   // gray order 00 10 11 01 is up, a leads b
   assign a = pos_q[0] ^ pos_q[1];
   assign b = pos_q[1];
   // three still cycles per detent so each phase is seen alone
   task automatic turn(input logic up, input int n);
      repeat (n)
      begin
         @(posedge clk);
         pos_q <= up ? pos_q + 2'h1 : pos_q - 2'h1;
         repeat (3) @(posedge clk);
      end
   endtask
endmodule // rotdec_knob_model

// ==== rotdec_params.svh ====
// constants of the rotary encoder decoder: offsets, widths, reset values
// assumes inclusion by bare name wherever the decoder or its tests need them
`ifndef ROTDEC_PARAMS_SVH
`define ROTDEC_PARAMS_SVH

// register byte addresses
`define ROTDEC_ADDR_STAT   32'hc600_0000
`define ROTDEC_ADDR_CTRL   32'hc600_0004
`define ROTDEC_ADDR_CNT    32'hc600_0008
`define ROTDEC_ADDR_W      32

// data widths
`define ROTDEC_DATA_W      32
`define ROTDEC_CNT_W       8
`define ROTDEC_NCHAN       2

// field positions
`define ROTDEC_CHAN0       0
`define ROTDEC_CHAN1       1
`define ROTDEC_CHAN0_DELTA_LSB    0
`define ROTDEC_CHAN1_DELTA_LSB    8

// reset values
`define ROTDEC_STAT_RST    2'h0
`define ROTDEC_CTRL_RST    2'h0
`define ROTDEC_CNT_RST     8'h00
`define ROTDEC_RDATA_RST   32'h0000_0000
`define ROTDEC_IRQ_RST     1'b0
`define ROTDEC_FILL_RST    2'h0

// timing counts: edges after reset until sync and prev hold pin samples
`define ROTDEC_SYNC_FILL   2'h3

`endif

// ==== rotdec_pkg.sv ====
// types shared by the rotary encoder decoder and its tests
// assumes rotdec_params.svh holds the numbers
package rotdec_pkg;

   // one encoder's phase pair
   typedef struct packed {
      logic a;
      logic b;
   } rotdec_phase_t;

   // direction of one quadrature step, one-hot
   typedef enum logic [2:0] {
      ROTDEC_STEP_NONE = 3'h1,
      ROTDEC_STEP_UP   = 3'h2,
      ROTDEC_STEP_DOWN = 3'h4
   } rotdec_step_t;

endpackage

// ==== rotdec_sva.sv ====
// checker: port-level properties of the rotary decoder
// assumes binding onto rotdec_top, one clock domain
`timescale 1ns/10ps
`include "rotdec_params.svh"
module rotdec_sva #(
   parameter int CNT_W = `ROTDEC_CNT_W
) (
   // clock and reset
   input wire logic        MCLK,
   input wire logic        SYS_RST,
   // encoder pins
   input wire logic        KNOB0_PHASE_A,
   input wire logic        KNOB0_PHASE_B,
   input wire logic        KNOB1_PHASE_A,
   input wire logic        KNOB1_PHASE_B,
   // register port
   input wire logic [31:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   // interrupt
   input wire logic        IRQ
);
   logic [3:0] pins;
   logic       rd_cnt;
   logic       rd_st;
   logic       rd_ct;
   logic       wr_ct;
   assign pins = {KNOB0_PHASE_A, KNOB0_PHASE_B, KNOB1_PHASE_A, KNOB1_PHASE_B};
   assign rd_cnt = REG_RD && REG_ADDR == `ROTDEC_ADDR_CNT;
   assign rd_st = REG_RD && REG_ADDR == `ROTDEC_ADDR_STAT;
   assign rd_ct = REG_RD && REG_ADDR == `ROTDEC_ADDR_CTRL;
   assign wr_ct = REG_WR && REG_ADDR == `ROTDEC_ADDR_CTRL;
   default clocking @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   // no pin edge can still be in the synchroniser
   sequence s_calm;
      ($stable(pins))[*4];
   endsequence
   sequence s_set_back;
      wr_ct ##1 rd_ct;
   endsequence
   chk_rdata_idle: assert property (REG_RDATA != 0 |-> $past(REG_RD))
      else $error("read data outside a read");
   chk_cnt_upper: assert property (rd_cnt |=> REG_RDATA[31:16] == 0)
      else $error("count upper bits set");
   chk_stat_upper: assert property (rd_st |=> REG_RDATA[31:2] == 0)
      else $error("status upper bits set");
   chk_ctrl_upper: assert property (rd_ct |=> REG_RDATA[31:2] == 0)
      else $error("control upper bits set");
   chk_ctrl_back: assert property (s_set_back |=> REG_RDATA == $past(REG_WDATA[1:0], 2))
      else $error("control readback wrong");
   chk_cnt_restart: assert property (s_calm ##0 rd_cnt ##1 (rd_cnt && $stable(pins)) |=> REG_RDATA == 0)
      else $error("count not restarted");
   chk_flag_clear: assert property (s_calm ##0 rd_cnt ##1 (rd_st && $stable(pins)) |=> REG_RDATA == 0)
      else $error("flags not cleared by read");
   chk_irq_off: assert property (wr_ct && REG_WDATA[1:0] == 0 ##1 !REG_WR |=> !IRQ)
      else $error("interrupt while disabled");
   chk_irq_hold: assert property (IRQ && !REG_WR && !REG_RD |=> IRQ)
      else $error("interrupt dropped without access");
endmodule // rotdec_sva

bind rotdec_top rotdec_sva #(.CNT_W(CNT_W)) chk_u (.MCLK(MCLK), .SYS_RST(SYS_RST),
   .KNOB0_PHASE_A(KNOB0_PHASE_A), .KNOB0_PHASE_B(KNOB0_PHASE_B), .KNOB1_PHASE_A(KNOB1_PHASE_A),
   .KNOB1_PHASE_B(KNOB1_PHASE_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));

// ==== rotdec_tb_top.sv ====
// testbench: decoder scenarios over the register port
// assumes one knob model on each encoder pin pair
`timescale 1ns/10ps
`include "rotdec_params.svh"
module rotdec_tb_top;
   localparam logic [31:0] A_ST = `ROTDEC_ADDR_STAT;
   localparam logic [31:0] A_CT = `ROTDEC_ADDR_CTRL;
   localparam logic [31:0] A_CN = `ROTDEC_ADDR_CNT;
   logic        MCLK = 1'b0;
   logic        SYS_RST = 1'b1;
   logic [31:0] addr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic        irq;
   logic        k0a;
   logic        k0b;
   logic        k1a;
   logic        k1b;
   int          num_errors = 0;
   int          n_checks = 0;
   always #20 MCLK = ~MCLK;
   rotdec_top dut_u (.MCLK(MCLK), .SYS_RST(SYS_RST), .KNOB0_PHASE_A(k0a), .KNOB0_PHASE_B(k0b),
      .KNOB1_PHASE_A(k1a), .KNOB1_PHASE_B(k1b), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .IRQ(irq));
   rotdec_knob_model k0_u (.clk(MCLK), .a(k0a), .b(k0b));
   rotdec_knob_model k1_u (.clk(MCLK), .a(k1a), .b(k1b));
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // strobes stay up until the next call, so back-to-back needs no gap
   task op(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      @(posedge MCLK);
      #1;
   endtask
   task rdc(input logic [31:0] a, input logic [31:0] exp);
      op(1'b0, 1'b1, a, 32'h0);
      chk(rdata, exp, "rdata");
   endtask
   task t_reset;
      rdc(A_ST, 32'h0);
      rdc(A_CT, 32'h0);
      rdc(A_CN, 32'h0);
      rdc(32'hc600_000c, 32'h0);
      op(1'b0, 1'b0, 32'h0, 32'h0);
   endtask
   task t_count;
      fork
         k0_u.turn(1'b1, 3);
         k1_u.turn(1'b0, 2);
      join
      op(1'b0, 1'b0, 32'h0, 32'h0);
      chk({31'h0, irq}, 32'h0, "irq");
      rdc(A_ST, 32'h3);
      op(1'b1, 1'b0, A_ST, 32'h1);
      rdc(A_ST, 32'h2);
      rdc(A_CN, 32'h0000_fe03);
      rdc(A_CN, 32'h0);
      rdc(A_ST, 32'h0);
      op(1'b0, 1'b0, 32'h0, 32'h0);
   endtask
   task t_sat;
      fork
         k0_u.turn(1'b1, 130);
         k1_u.turn(1'b0, 130);
      join
      op(1'b1, 1'b0, A_CN, 32'h0);
      rdc(A_CN, 32'h0000_807f);
      op(1'b0, 1'b0, 32'h0, 32'h0);
   endtask
   // reset in mid-run with knob 0 resting at 10: no false step afterwards
   task t_rst;
      @(posedge MCLK);
      SYS_RST <= 1'b1;
      repeat (10) @(posedge MCLK);
      SYS_RST <= 1'b0;
      repeat (8) @(posedge MCLK);
      #1;
      rdc(A_CN, 32'h0);
      rdc(A_ST, 32'h0);
      rdc(A_CT, 32'h0);
      op(1'b0, 1'b0, 32'h0, 32'h0);
   endtask
   task t_irq;
      op(1'b1, 1'b0, A_CT, 32'h1);
      rdc(A_CT, 32'h1);
      op(1'b0, 1'b0, 32'h0, 32'h0);
      k1_u.turn(1'b1, 1);
      op(1'b0, 1'b0, 32'h0, 32'h0);
      chk({31'h0, irq}, 32'h0, "irq");
      rdc(A_CN, 32'h0000_0100);
      op(1'b0, 1'b0, 32'h0, 32'h0);
      k0_u.turn(1'b0, 1);
      op(1'b0, 1'b0, 32'h0, 32'h0);
      chk({31'h0, irq}, 32'h1, "irq");
      rdc(A_CN, 32'h0000_00ff);
      op(1'b0, 1'b0, 32'h0, 32'h0);
      chk({31'h0, irq}, 32'h0, "irq");
      op(1'b1, 1'b0, A_CT, 32'h2);
      rdc(A_CT, 32'h2);
      op(1'b0, 1'b0, 32'h0, 32'h0);
      k1_u.turn(1'b0, 1);
      op(1'b0, 1'b0, 32'h0, 32'h0);
      chk({31'h0, irq}, 32'h1, "irq");
      op(1'b1, 1'b0, A_CT, 32'h0);
      op(1'b0, 1'b0, 32'h0, 32'h0);
      chk({31'h0, irq}, 32'h0, "irq");
      rdc(A_CN, 32'h0000_ff00);
      op(1'b0, 1'b0, 32'h0, 32'h0);
   endtask
   task results;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge MCLK);
      SYS_RST <= 1'b0;
      #1;
      t_reset;
      t_count;
      t_sat;
      t_rst;
      t_irq;
      results;
   end
   // run needs under 2000 cycles; limit is well beyond that
   initial
   begin
      #200000;
      num_errors++;
      results;
   end
endmodule // rotdec_tb_top

// ==== rotdec_top.sv ====
// rotary encoder decoder: two quadrature channels, movement counts, flags
// and one level interrupt behind a plain register port
// assumes encoder pins are asynchronous to MCLK and pass two flops here
// assumes a single-cycle register master that never waits
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`include "rotdec_params.svh"

module rotdec_top #(
   parameter int CNT_W = `ROTDEC_CNT_W
) (
   // clock and reset
   input  wire logic                       MCLK,
   input  wire logic                       SYS_RST,
   // encoder pins
   input  wire logic                       KNOB0_PHASE_A,
   input  wire logic                       KNOB0_PHASE_B,
   input  wire logic                       KNOB1_PHASE_A,
   input  wire logic                       KNOB1_PHASE_B,
   // register port
   input  wire logic [`ROTDEC_ADDR_W-1:0]  REG_ADDR,
   input  wire logic [`ROTDEC_DATA_W-1:0]  REG_WDATA,
   input  wire logic                       REG_WR,
   input  wire logic                       REG_RD,
   output logic      [`ROTDEC_DATA_W-1:0]  REG_RDATA,
   // interrupt
   output logic                            IRQ
);

   localparam int NCH = `ROTDEC_NCHAN;

   typedef logic signed [CNT_W-1:0] cnt_t;

   // raw pins as phase pairs
   rotdec_pkg::rotdec_phase_t [NCH-1:0] pin_raw;

   // two-stage synchronisers and last sampled phase
   rotdec_pkg::rotdec_phase_t [NCH-1:0] pin_meta_q;
   rotdec_pkg::rotdec_phase_t [NCH-1:0] pin_sync_q;
   rotdec_pkg::rotdec_phase_t [NCH-1:0] pin_prev_q;

   // per channel state
   cnt_t                     delta_q [NCH];
   cnt_t                     delta_d [NCH];
   cnt_t                     delta_base [NCH];
   rotdec_pkg::rotdec_step_t step_c [NCH];
   logic [NCH-1:0]           moved_c;

   // registers
   logic [NCH-1:0]           changed_q;
   logic [NCH-1:0]           changed_d;
   logic [NCH-1:0]           irq_en_q;
   logic [NCH-1:0]           irq_en_d;
   logic                     irq_q;
   logic                     irq_d;
   logic [`ROTDEC_DATA_W-1:0] rdata_q;
   logic [`ROTDEC_DATA_W-1:0] rdata_d;

   // decoded accesses
   logic                     wr_stat;
   logic                     wr_ctrl;
   logic                     rd_cnt;
   logic                     rd_stat;
   logic                     rd_ctrl;
   logic [NCH-1:0]           stat_w1c;

   // synchroniser warm-up after reset
   logic [1:0]               fill_q;
   logic                     primed;

   // full address compare: the decode is used by reads and writes alike
   function automatic logic addr_hit(
      input logic [`ROTDEC_ADDR_W-1:0] addr,
      input logic [`ROTDEC_ADDR_W-1:0] target
   );
      addr_hit = (addr == target);
   endfunction

   // one step of a gray sequence 00,10,11,01 read as {a,b}
   function automatic rotdec_pkg::rotdec_step_t quad_step(
      input rotdec_pkg::rotdec_phase_t prev,
      input rotdec_pkg::rotdec_phase_t cur
   );
      logic [3:0] pair;
      pair = {prev.a, prev.b, cur.a, cur.b};
      case (pair)
         4'h2, 4'hb, 4'hd, 4'h4:
            quad_step = rotdec_pkg::ROTDEC_STEP_UP;
         4'h1, 4'h7, 4'he, 4'h8:
            quad_step = rotdec_pkg::ROTDEC_STEP_DOWN;
         // no movement, or both phases moved at once: ambiguous, dropped
         default:
            quad_step = rotdec_pkg::ROTDEC_STEP_NONE;
      endcase
   endfunction

   // saturating add of one step
   // holding at a limit keeps the sign right through a fast spin
   function automatic cnt_t sat_step(
      input cnt_t                     cur,
      input rotdec_pkg::rotdec_step_t step
   );
      cnt_t cmax;
      cnt_t cmin;
      cmax = {1'b0, {(CNT_W-1){1'b1}}};
      cmin = {1'b1, {(CNT_W-1){1'b0}}};
      case (step)
         rotdec_pkg::ROTDEC_STEP_UP:
            sat_step = (cur == cmax) ? cur : cnt_t'(cur + cnt_t'(1));
         rotdec_pkg::ROTDEC_STEP_DOWN:
            sat_step = (cur == cmin) ? cur : cnt_t'(cur - cnt_t'(1));
         default:
            sat_step = cur;
      endcase
   endfunction

   // pin grouping
   assign pin_raw[`ROTDEC_CHAN0].a = KNOB0_PHASE_A;
   assign pin_raw[`ROTDEC_CHAN0].b = KNOB0_PHASE_B;
   assign pin_raw[`ROTDEC_CHAN1].a = KNOB1_PHASE_A;
   assign pin_raw[`ROTDEC_CHAN1].b = KNOB1_PHASE_B;

   // access decode
   always_comb
   begin
      wr_stat  = REG_WR && addr_hit(REG_ADDR, `ROTDEC_ADDR_STAT);
      wr_ctrl  = REG_WR && addr_hit(REG_ADDR, `ROTDEC_ADDR_CTRL);
      rd_cnt   = REG_RD && addr_hit(REG_ADDR, `ROTDEC_ADDR_CNT);
      rd_stat  = REG_RD && addr_hit(REG_ADDR, `ROTDEC_ADDR_STAT);
      rd_ctrl  = REG_RD && addr_hit(REG_ADDR, `ROTDEC_ADDR_CTRL);
      stat_w1c = wr_stat ? REG_WDATA[NCH-1:0] : '0;
   end

   // pin synchronisers; meta stage feeds only the sync stage
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end
      else
      begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
      end
   end

   // previous phase, reloaded every cycle
   // prev follows sync one cycle behind; a step is a change between the two
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         pin_prev_q <= '0;
      else
         pin_prev_q <= pin_sync_q;
   end

   // warm-up: steps are held off until sync and prev both hold pin samples,
   // so a knob resting away from 00 through reset counts no false step;
   // the price is that a turn landing before the first edge after reset is lost
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         fill_q <= `ROTDEC_FILL_RST;
      else if (!primed)
         fill_q <= fill_q + 2'h1;
   end

   assign primed = (fill_q == `ROTDEC_SYNC_FILL);

   // step detection and next count
   always_comb
   begin
      for (int ch = 0; ch < NCH; ch++)
      begin
         step_c[ch]     = quad_step(pin_prev_q[ch], pin_sync_q[ch]);
         if (!primed)
            step_c[ch] = rotdec_pkg::ROTDEC_STEP_NONE;
         // a read restarts from zero but a step in the same cycle still counts
         delta_base[ch] = rd_cnt ? cnt_t'(`ROTDEC_CNT_RST) : delta_q[ch];
         delta_d[ch]    = sat_step(delta_base[ch], step_c[ch]);
         // a step held off by saturation is no change
         moved_c[ch]    = (delta_d[ch] != delta_base[ch]);
      end
   end

   // movement counts
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         for (int ch = 0; ch < NCH; ch++)
            delta_q[ch] <= cnt_t'(`ROTDEC_CNT_RST);
      end
      else
      begin
         for (int ch = 0; ch < NCH; ch++)
            delta_q[ch] <= delta_d[ch];
      end
   end

   // change flags: a change in the clearing cycle wins over the clear
   // so a step that lands with the count read is never lost
   always_comb
   begin
      changed_d = changed_q;
      if (rd_cnt)
      begin
         changed_d = '0;
      end
      changed_d = changed_d & ~stat_w1c;
      changed_d[`ROTDEC_CHAN0] = changed_d[`ROTDEC_CHAN0] | moved_c[`ROTDEC_CHAN0];
      changed_d[`ROTDEC_CHAN1] = changed_d[`ROTDEC_CHAN1] | moved_c[`ROTDEC_CHAN1];
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         changed_q <= `ROTDEC_STAT_RST;
      else
         changed_q <= changed_d;
   end

   // interrupt enables; control bits above the channels are ignored
   always_comb
   begin
      irq_en_d = irq_en_q;
      if (wr_ctrl)
      begin
         irq_en_d[`ROTDEC_CHAN0] = REG_WDATA[`ROTDEC_CHAN0];
         irq_en_d[`ROTDEC_CHAN1] = REG_WDATA[`ROTDEC_CHAN1];
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         irq_en_q <= `ROTDEC_CTRL_RST;
      else
         irq_en_q <= irq_en_d;
   end

   // interrupt level from next flags and next enables, so IRQ is the exact
   // registered image of flag and enable: no extra cycle after a mask write
   always_comb
   begin
      irq_d = 1'b0;
      for (int ch = 0; ch < NCH; ch++)
         irq_d = irq_d | (changed_d[ch] & irq_en_d[ch]);
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         irq_q <= `ROTDEC_IRQ_RST;
      else
         irq_q <= irq_d;
   end

   // read mux; unmapped addresses and reserved bits read zero
   always_comb
   begin
      rdata_d = `ROTDEC_RDATA_RST;
      if (REG_RD)
      begin
         // one decode serves reads and writes alike
         if (rd_stat)
            rdata_d[NCH-1:0] = changed_q;
         else if (rd_ctrl)
            rdata_d[NCH-1:0] = irq_en_q;
         else if (rd_cnt)
         begin
            // counts before the restart go out
            rdata_d[`ROTDEC_CHAN0_DELTA_LSB +: CNT_W] = delta_q[`ROTDEC_CHAN0];
            rdata_d[`ROTDEC_CHAN1_DELTA_LSB +: CNT_W] = delta_q[`ROTDEC_CHAN1];
         end
      end
   end

   // read data stands only in the cycle after the strobe
   // and then falls back to zero, so a stale word never shows twice
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         rdata_q <= `ROTDEC_RDATA_RST;
      else
         rdata_q <= rdata_d;
   end

   // outputs
   assign REG_RDATA = rdata_q;
   assign IRQ       = irq_q;

endmodule // rotdec_top
